// File: rtl/aff_params.svh
`ifndef AFF_PARAMS_SVH
`define AFF_PARAMS_SVH

// ********************************************************************
// Clock and timing figures.
// ********************************************************************
`define AFF_CLK_PERIOD_NS    50
`define AFF_STROBE_HIGH_NS   80
`define AFF_STROBE_LOW_NS    80
`define AFF_CLEAR_WIDTH_NS   400
`define AFF_CLEAR_RECOVER_NS 30
`define AFF_RIPPLE_NS        1000
`define AFF_CYC_UP(ns)       (((ns) + `AFF_CLK_PERIOD_NS - 1) / `AFF_CLK_PERIOD_NS)
`define AFF_STROBE_HIGH_CYC  `AFF_CYC_UP(`AFF_STROBE_HIGH_NS)
`define AFF_STROBE_LOW_CYC   `AFF_CYC_UP(`AFF_STROBE_LOW_NS)
`define AFF_CLEAR_WIDTH_CYC  `AFF_CYC_UP(`AFF_CLEAR_WIDTH_NS)
`define AFF_CLEAR_RECOV_CYC  `AFF_CYC_UP(`AFF_CLEAR_RECOVER_NS)
`define AFF_RIPPLE_CYC       `AFF_CYC_UP(`AFF_RIPPLE_NS)

// ********************************************************************
// Device organisation.
// ********************************************************************
`define AFF_WORD_WIDTH       4
`define AFF_DEPTH            64
`define AFF_COUNT_WIDTH      6

`endif

// File: rtl/aff_pkg.sv
`include "aff_params.svh"

package aff_pkg;

  typedef struct packed {
    logic                        masterClearN;
    logic                        pushStrobe;
    logic [`AFF_WORD_WIDTH-1:0]  inWord;
    logic                        popStrobe;
  } aff_dev_out_type;

  typedef struct packed {
    logic                        acceptFlag;
    logic                        validFlag;
    logic [`AFF_WORD_WIDTH-1:0]  outWord;
  } aff_dev_in_type;

  typedef enum logic [1:0] {
    CLR_ASSERT,
    CLR_RECOVER,
    CLR_RUN
  } aff_clear_state_type;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_HIGH,
    WR_LOW
  } aff_write_state_type;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_HIGH,
    RD_LOW
  } aff_read_state_type;

endpackage

// File: rtl/aff_low_timer.sv
`timescale 1ns/100ps
`include "aff_params.svh"

// ********************************************************************
// Reports a flag that has stayed low for a given number of cycles.
// ********************************************************************
module aff_low_timer #(
  parameter int CW    = `AFF_COUNT_WIDTH,
  parameter int LIMIT = `AFF_RIPPLE_CYC
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  input  wire logic armed,
  input  wire logic level,
  output logic      stuckLow
);

  localparam logic [CW-1:0] LimitC = CW'(LIMIT);

  logic [CW-1:0] lowCnt_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      lowCnt_q <= '0;
    end
    else if (clkEn)
    begin
      if (!armed || level)
      begin
        lowCnt_q <= '0;
      end
      else if (lowCnt_q != LimitC)
      begin
        lowCnt_q <= lowCnt_q + CW'(1);
      end
    end
  end

  assign stuckLow = (lowCnt_q == LimitC);

endmodule

// File: rtl/aff_host.sv
`timescale 1ns/100ps
`include "aff_params.svh"

// Contract
// RULE1 - The device holds sixty-four four-bit words in first-in first-out order.
// RULE2 - Write and read sides run independently with no shared clock.
// RULE3 - Push strobe rises only while accept flag is high; device then drops accept.
// RULE4 - Word held in first stage until accept and push both low.
// RULE5 - Device raises accept after word leaves first stage; stays low when full.
// RULE6 - Occupied stages pass words toward output without outside action.
// RULE7 - Ripple-through time spans input to output for a word or vacancy.
// RULE8 - Word reaching last stage raises valid flag and appears on output word.
// RULE9 - Pop strobe rises only while valid high; output held until both low.
// RULE10 - After pop completes, next word moves out and valid rises, unless empty.
// RULE11 - Accept or valid low for a ripple-through time means full or empty.
// RULE12 - Master clear empties every stage and drives output word low.
// RULE13 - After clear, valid stays low; accept rises only if push was low.
// RULE14 - Device model uses staged register array; inputs synchronised; one advance per step. The host samples devIn directly on clk, unsynchronised.
module aff_host #(
  parameter int WW       = `AFF_WORD_WIDTH,
  parameter int CW       = `AFF_COUNT_WIDTH,
  parameter int HIGH_CYC = `AFF_STROBE_HIGH_CYC,
  parameter int LOW_CYC  = `AFF_STROBE_LOW_CYC,
  parameter int CLR_CYC  = `AFF_CLEAR_WIDTH_CYC,
  parameter int REC_CYC  = `AFF_CLEAR_RECOV_CYC,
  parameter int RIP_CYC  = `AFF_RIPPLE_CYC
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             clkEn,
  input  wire logic             clearReq,
  input  wire logic             wrValid,
  input  wire logic [WW-1:0]    wrData,
  output logic                  wrReady,
  output logic                  rdValid,
  output logic [WW-1:0]         rdData,
  input  wire logic             rdReady,
  output logic                  fifoFull,
  output logic                  fifoEmpty,
  output logic                  busy,
  output aff_pkg::aff_dev_out_type devOut,
  input  wire aff_pkg::aff_dev_in_type devIn
);

  localparam logic [CW-1:0] HighC = CW'(HIGH_CYC - 1);
  localparam logic [CW-1:0] LowC  = CW'(LOW_CYC - 1);
  localparam logic [CW-1:0] ClrC  = CW'(CLR_CYC - 1);
  localparam logic [CW-1:0] RecC  = CW'(REC_CYC - 1);

  aff_pkg::aff_clear_state_type clrState_q;
  aff_pkg::aff_write_state_type wrState_q;
  aff_pkg::aff_read_state_type  rdState_q;
  logic [CW-1:0]                clrCnt_q;
  logic [CW-1:0]                wrCnt_q;
  logic [CW-1:0]                rdCnt_q;
  logic                         masterClearN_q;
  logic                         pushStrobe_q;
  logic [WW-1:0]                inWord_q;
  logic                         popStrobe_q;
  logic                         rdValid_q;
  logic [WW-1:0]                rdData_q;
  logic                         running;

  // ******************************************************************
  // Master clear sequencing.
  // ******************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      clrState_q     <= aff_pkg::CLR_ASSERT;
      clrCnt_q       <= '0;
      masterClearN_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (clearReq && clrState_q == aff_pkg::CLR_RUN)
      begin
        clrState_q     <= aff_pkg::CLR_ASSERT;
        clrCnt_q       <= '0;
        masterClearN_q <= 1'b0;
      end
      else
      begin
        unique case (clrState_q)
          aff_pkg::CLR_ASSERT:
          begin
            if (clrCnt_q == ClrC)
            begin
              clrState_q     <= aff_pkg::CLR_RECOVER;
              clrCnt_q       <= '0;
              masterClearN_q <= 1'b1;
            end
            else
            begin
              clrCnt_q <= clrCnt_q + CW'(1);
            end
          end
          aff_pkg::CLR_RECOVER:
          begin
            if (clrCnt_q == RecC)
            begin
              clrState_q <= aff_pkg::CLR_RUN;
            end
            else
            begin
              clrCnt_q <= clrCnt_q + CW'(1);
            end
          end
          aff_pkg::CLR_RUN:
          begin
            clrCnt_q <= '0;
          end
        endcase
      end
    end
  end

  assign running = (clrState_q == aff_pkg::CLR_RUN);

  // ******************************************************************
  // Write handshake.
  // ******************************************************************
  assign wrReady = running && wrState_q == aff_pkg::WR_IDLE && devIn.acceptFlag; // RULE3

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wrState_q    <= aff_pkg::WR_IDLE;
      wrCnt_q      <= '0;
      pushStrobe_q <= 1'b0;
      inWord_q     <= '0;
    end
    else if (clkEn)
    begin
      if (!running)
      begin
        wrState_q    <= aff_pkg::WR_IDLE;
        wrCnt_q      <= '0;
        pushStrobe_q <= 1'b0; // RULE13
      end
      else
      begin
        unique case (wrState_q)
          aff_pkg::WR_IDLE:
          begin
            if (wrValid && wrReady)
            begin
              inWord_q     <= wrData;
              pushStrobe_q <= 1'b1; // RULE3
              wrCnt_q      <= '0;
              wrState_q    <= aff_pkg::WR_HIGH;
            end
          end
          aff_pkg::WR_HIGH:
          begin
            if (wrCnt_q != HighC)
            begin
              wrCnt_q <= wrCnt_q + CW'(1);
            end
            else if (!devIn.acceptFlag)
            begin
              pushStrobe_q <= 1'b0; // RULE4
              wrCnt_q      <= '0;
              wrState_q    <= aff_pkg::WR_LOW;
            end
          end
          aff_pkg::WR_LOW:
          begin
            if (wrCnt_q != LowC)
            begin
              wrCnt_q <= wrCnt_q + CW'(1);
            end
            else
            begin
              wrState_q <= aff_pkg::WR_IDLE; // RULE5
            end
          end
        endcase
      end
    end
  end

  // ******************************************************************
  // Read handshake.
  // ******************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdState_q   <= aff_pkg::RD_IDLE;
      rdCnt_q     <= '0;
      popStrobe_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!running)
      begin
        rdState_q   <= aff_pkg::RD_IDLE;
        rdCnt_q     <= '0;
        popStrobe_q <= 1'b0;
      end
      else
      begin
        unique case (rdState_q)
          aff_pkg::RD_IDLE:
          begin
            if (devIn.validFlag && (!rdValid_q || rdReady))
            begin
              popStrobe_q <= 1'b1; // RULE9
              rdCnt_q     <= '0;
              rdState_q   <= aff_pkg::RD_HIGH;
            end
          end
          aff_pkg::RD_HIGH:
          begin
            if (rdCnt_q != HighC)
            begin
              rdCnt_q <= rdCnt_q + CW'(1);
            end
            else if (!devIn.validFlag)
            begin
              popStrobe_q <= 1'b0; // RULE9
              rdCnt_q     <= '0;
              rdState_q   <= aff_pkg::RD_LOW;
            end
          end
          aff_pkg::RD_LOW:
          begin
            if (rdCnt_q != LowC)
            begin
              rdCnt_q <= rdCnt_q + CW'(1);
            end
            else
            begin
              rdState_q <= aff_pkg::RD_IDLE; // RULE10
            end
          end
        endcase
      end
    end
  end

  // ******************************************************************
  // Output word holding register toward the user.
  // ******************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdValid_q <= 1'b0;
      rdData_q  <= '0;
    end
    else if (clkEn)
    begin
      if (running && rdState_q == aff_pkg::RD_IDLE && devIn.validFlag && (!rdValid_q || rdReady))
      begin
        rdValid_q <= 1'b1;
        rdData_q  <= devIn.outWord; // RULE8
      end
      else if (rdReady || !running)
      begin
        rdValid_q <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Full and empty detection.
  // ******************************************************************
  aff_low_timer #(
    .CW    (CW),
    .LIMIT (RIP_CYC)
  ) fullTimer (
    .clk      (clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .armed    (running),
    .level    (devIn.acceptFlag),
    .stuckLow (fifoFull)
  ); // RULE11

  aff_low_timer #(
    .CW    (CW),
    .LIMIT (RIP_CYC)
  ) emptyTimer (
    .clk      (clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .armed    (running),
    .level    (devIn.validFlag),
    .stuckLow (fifoEmpty)
  ); // RULE11

  assign rdValid             = rdValid_q;
  assign rdData              = rdData_q;
  assign busy                = !running;
  assign devOut.masterClearN = masterClearN_q; // RULE12
  assign devOut.pushStrobe   = pushStrobe_q;
  assign devOut.inWord       = inWord_q;
  assign devOut.popStrobe    = popStrobe_q;

endmodule

// File: test/aff_host_props.sv
`timescale 1ns/100ps
`include "aff_params.svh"

// ********************************************************************
// Handshake and clear checks at the host ports.
// ********************************************************************
module aff_host_props (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic                       clkEn,
  input wire logic                       wrReady,
  input wire logic                       rdValid,
  input wire logic [`AFF_WORD_WIDTH-1:0] rdData,
  input wire logic                       fifoFull,
  input wire logic                       fifoEmpty,
  input wire logic                       busy,
  input wire aff_pkg::aff_dev_out_type   devOut,
  input wire aff_pkg::aff_dev_in_type    devIn
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  push_needs_accept_a: assert property ($rose(devOut.pushStrobe) |-> $past(devIn.acceptFlag))
    else $error("push raised without accept");
  push_hold_a: assert property (devOut.pushStrobe && devIn.acceptFlag |=> devOut.pushStrobe)
    else $error("push dropped while accept high");
  word_stable_a: assert property (devOut.pushStrobe && $past(devOut.pushStrobe) |-> $stable(devOut.inWord))
    else $error("word changed during push");
  pop_needs_valid_a: assert property ($rose(devOut.popStrobe) |-> $past(devIn.validFlag))
    else $error("pop raised without valid");
  pop_data_a: assert property ($rose(devOut.popStrobe) |-> rdValid && rdData == $past(devIn.outWord))
    else $error("popped word not delivered");
  pop_release_a: assert property ($fell(devOut.popStrobe) |-> !$past(devIn.validFlag))
    else $error("pop released while valid high");
  clear_width_a: assert property ($rose(devOut.masterClearN) |-> $past(devOut.masterClearN, 8) == 1'b0)
    else $error("clear too short");
  busy_quiet_a: assert property (busy |-> !devOut.pushStrobe && !wrReady)
    else $error("write activity during clear");
  full_flag_a: assert property (fifoFull && $past(clkEn) |-> !$past(devIn.acceptFlag))
    else $error("full while accept high");
  empty_flag_a: assert property (fifoEmpty && $past(clkEn) |-> !$past(devIn.validFlag))
    else $error("empty while valid high");
endmodule

bind aff_host aff_host_props i_props (
  .clk(clk), .resetn(resetn), .clkEn(clkEn), .wrReady(wrReady), .rdValid(rdValid), .rdData(rdData),
  .fifoFull(fifoFull), .fifoEmpty(fifoEmpty), .busy(busy), .devOut(devOut), .devIn(devIn)
);

// File: test/aff_dev_model.sv
`timescale 1ns/100ps
`include "aff_params.svh"

// ********************************************************************
// Behavioural fall-through buffer driven by the host pins.
// ********************************************************************
module aff_dev_model (
  input  wire logic                     clk,
  input  wire aff_pkg::aff_dev_out_type devOut,
  output aff_pkg::aff_dev_in_type       devIn
);
  logic [`AFF_WORD_WIDTH-1:0] stg[`AFF_DEPTH];
  logic [`AFF_DEPTH-1:0]      occ;
  logic                       popping;
  logic                       released;
  initial
  begin
    devIn = '0;
    occ = '0;
    popping = 1'b0;
    released = 1'b0;
  end
  always @(posedge clk)
  begin
    released = 1'b0;
    if (!devOut.masterClearN)
    begin
      occ = '0;
      popping = 1'b0;
      devIn <= '0;
    end
    else
    begin
      if (devIn.validFlag && devOut.popStrobe)
      begin
        devIn.validFlag <= 1'b0;
        popping = 1'b1;
      end
      else if (popping && !devOut.popStrobe)
      begin
        occ[`AFF_DEPTH-1] = 1'b0;
        popping = 1'b0;
        released = 1'b1;
      end
      if (devIn.acceptFlag && devOut.pushStrobe)
      begin
        stg[0] = devOut.inWord;
        occ[0] = 1'b1;
        devIn.acceptFlag <= 1'b0;
      end
      // Four internal steps per clock keep the ripple-through time under the host's timer.
      repeat (4)
      begin
        for (int i = `AFF_DEPTH - 2; i >= 0; i--)
        begin
          if (occ[i] && !occ[i+1] && (i > 0 || (!devIn.acceptFlag && !devOut.pushStrobe)))
          begin
            stg[i+1] = stg[i];
            occ[i+1] = 1'b1;
            occ[i] = 1'b0;
          end
        end
      end
      if (!devIn.acceptFlag && !devOut.pushStrobe && !occ[0])
        devIn.acceptFlag <= 1'b1;
      if (!popping && !devIn.validFlag && occ[`AFF_DEPTH-1])
      begin
        devIn.validFlag <= 1'b1;
        devIn.outWord <= stg[`AFF_DEPTH-1];
      end
      else if (released)
        devIn.outWord <= ~devIn.outWord;
    end
  end
endmodule

// File: test/testbench.sv
`timescale 1ns/100ps
`include "aff_params.svh"

// ********************************************************************
// Self-checking bench with random traffic on both user sides.
// ********************************************************************
module testbench;
  logic                       clk, resetn, clkEn, clearReq, wrValid, rdReady;
  logic [`AFF_WORD_WIDTH-1:0] wrData;
  logic                       wrReady, rdValid, fifoFull, fifoEmpty, busy;
  logic [`AFF_WORD_WIDTH-1:0] rdData;
  aff_pkg::aff_dev_out_type   devOut;
  aff_pkg::aff_dev_in_type    devIn;
  logic [31:0]                seed;
  int                         miscompares, checks, nw;
  logic                       wrOn, rdOn, jit, wt, rt;
  logic [`AFF_WORD_WIDTH-1:0] expQ[$];

  aff_host i_dut (
    .clk(clk), .resetn(resetn), .clkEn(clkEn), .clearReq(clearReq), .wrValid(wrValid), .wrData(wrData),
    .wrReady(wrReady), .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady), .fifoFull(fifoFull),
    .fifoEmpty(fifoEmpty), .busy(busy), .devOut(devOut), .devIn(devIn)
  );
  aff_dev_model i_dev (.clk(clk), .devOut(devOut), .devIn(devIn));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic ok(input int sel);
    case (sel)
      0: return busy === 1'b0;
      default: return expQ.size() == 0 && rdValid === 1'b0;
    endcase
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_for(input int sel, input int lim);
    for (int i = 0; i < lim && !ok(sel); i++)
      @(posedge clk);
    if (!ok(sel))
    begin
      miscompares++;
      $display("BAD wait%0d expected 1 seen 0", sel);
      tally_and_finish();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(negedge clk)
  begin
    wt = wrValid & wrReady & clkEn & resetn;
    rt = rdValid & rdReady & clkEn & resetn;
    if (wt)
    begin
      expQ.push_back(wrData);
      nw++;
    end
    if (rt)
    begin
      chk("spare", expQ.size() > 0, 1);
      if (expQ.size() > 0)
        chk("rdData", rdData, expQ.pop_front());
    end
  end

  always @(posedge clk)
  begin
    #1;
    seed = xs(seed);
    wrValid = wrOn & seed[0];
    wrData = seed[7:4];
    rdReady = rdOn & (seed[1] | seed[2]);
    clkEn = !(jit && seed[10:8] == 3'h0);
  end

  initial
  begin
    seed = 32'h87234aba;
    {resetn, clearReq, wrValid, rdReady, wrOn, rdOn, jit} = '0;
    clkEn = 1'b1;
    wrData = '0;
    {miscompares, checks, nw} = '0;
    cyc(20);
    #1 resetn = 1'b1;
    wait_for(0, 100);
    cyc(30);
    chk("fifoEmpty", fifoEmpty, 1);
    chk("rdValid", rdValid, 0);
    chk("fifoFull", fifoFull, 0);
    $display("test empty done");
    {wrOn, rdOn, jit} = 3'h7;
    for (int i = 0; i < 6000 && nw < 200; i++)
      @(posedge clk);
    {wrOn, jit} = 2'h0;
    wait_for(1, 3000);
    chk("written", nw >= 200, 1);
    $display("test stream done");
    rdOn = 1'b0;
    nw = 0;
    wrOn = 1'b1;
    cyc(1500);
    chk("accepted", nw, 65);
    chk("fifoFull", fifoFull, 1);
    chk("wrReady", wrReady, 0);
    {wrOn, rdOn} = 2'h1;
    wait_for(1, 3000);
    cyc(30);
    chk("fifoEmpty", fifoEmpty, 1);
    $display("test fill done");
    {wrOn, rdOn} = 2'h2;
    cyc(60);
    wrOn = 1'b0;
    cyc(10);
    #1 clearReq = 1'b1;
    cyc(1);
    #1 clearReq = 1'b0;
    cyc(2);
    wait_for(0, 100);
    cyc(30);
    chk("fifoEmpty", fifoEmpty, 1);
    if (rdValid !== 1'b1)
      expQ.delete();
    else
      expQ = expQ[0:0];
    {wrOn, rdOn} = 2'h3;
    cyc(300);
    wrOn = 1'b0;
    wait_for(1, 3000);
    $display("test clear done");
    tally_and_finish();
  end
endmodule
